// ===== dv/gate_driver_model.sv
// gate driver model: latches the pin levels driven into it
`timescale 1ns/1ps
`default_nettype none
module gate_driver_model (
    input wire logic       clk_i,
    input wire logic [3:0] pin_i,
    output logic [3:0]     gate_o
);
    always_ff @(posedge clk_i) gate_o <= pin_i;
endmodule
`default_nettype wire

// ===== dv/test_waveform_shutdown_restart.sv
// self-checking bench of the shutdown and restart block
`timescale 1ns/1ps
`default_nettype none
module test_waveform_shutdown_restart;
    localparam NSRC = 4;
    logic       CLK_I, RESETN_I, WR_I, RD_I, SRC_EDGE_I, SHUTDOWN_ACTIVE_O, IRQ_O;
    logic [3:0] ADDR_I, WAVE_I, PIN_O, gate, SHUTDOWN_IN_I, lvl, pol;
    logic [7:0] WDATA_I, RDATA_O;
    logic [1:0] ien;
    int         n_mismatch = 0, n_checks = 0, cycles = 0;
    waveform_shutdown_restart #(.NSRC(NSRC)) uut (.CLK_I(CLK_I), .RESETN_I(RESETN_I), .ADDR_I(ADDR_I),
        .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .WAVE_I(WAVE_I), .SRC_EDGE_I(SRC_EDGE_I),
        .SHUTDOWN_IN_I(SHUTDOWN_IN_I), .PIN_O(PIN_O), .SHUTDOWN_ACTIVE_O(SHUTDOWN_ACTIVE_O), .IRQ_O(IRQ_O));
    gate_driver_model drv (.clk_i(CLK_I), .pin_i(PIN_O), .gate_o(gate));
    // ==========================================================
    // clock, watchdog, shared tasks
    initial begin
        CLK_I = 1'b0;
        forever #25 CLK_I = ~CLK_I;
    end
    always @(posedge CLK_I) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            summarize();
        end
    end
    task summarize();
        if (n_mismatch == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge CLK_I);
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge CLK_I);
        WR_I <= 1'b1; ADDR_I <= a; WDATA_I <= d;
        @(posedge CLK_I);
        WR_I <= 1'b0;
    endtask
    task rd(input logic [3:0] a, output logic [7:0] q);
        @(posedge CLK_I);
        RD_I <= 1'b1; ADDR_I <= a;
        @(posedge CLK_I);
        RD_I <= 1'b0;
        #1 q = RDATA_O;
    endtask
    // source edge long enough for the synchroniser, then quiet
    task src_pulse();
        SRC_EDGE_I <= 1'b1;
        cyc(2);
        SRC_EDGE_I <= 1'b0;
        cyc(6);
    endtask
    function logic [7:0] ovr(input logic [3:0] l);
        return {4'h0, l[3], l[1], l[2], l[0]};
    endfunction
    // ==========================================================
    // main sequence
    initial begin
        logic [7:0] q;
        int         i;
        {WR_I, RD_I, SRC_EDGE_I} = 3'h0;
        {ADDR_I, WAVE_I, SHUTDOWN_IN_I} = 12'h000;
        WDATA_I = 8'h00;
        RESETN_I = 1'b0;
        void'($urandom(32'h09e8));
        cyc(16);
        RESETN_I <= 1'b1;
        cyc(3);
        chk({3'h0, SHUTDOWN_ACTIVE_O, gate}, 8'h10);
        wr(4'h2, 8'h0F);
        wr(4'h1, 8'h02);
        wr(4'h0, 8'h00);
        src_pulse();
        for (i = 0; i < 4; i++) begin
            lvl = (i == 0) ? 4'hF : 4'($urandom);
            pol = (i == 1) ? 4'h0 : 4'($urandom);
            ien = (i == 3) ? 2'h0 : 2'h3;
            WAVE_I <= 4'($urandom);
            wr(4'h0, {4'h0, lvl});
            wr(4'h1, {pol, 3'h1, i[0]});
            wr(4'h5, {6'h0, ien});
            SHUTDOWN_IN_I <= 4'h1 << i;
            cyc(6);
            chk({3'h0, SHUTDOWN_ACTIVE_O, gate}, 8'h10 | ovr(lvl));
            wr(4'h0, {4'h0, lvl});
            rd(4'h0, q);
            chk(q, {4'h8, lvl});
            SHUTDOWN_IN_I <= 4'h0;
            cyc(6);
            if (!i[0]) wr(4'h0, {4'h0, lvl});
            rd(4'h0, q);
            chk(q, {4'h0, lvl});
            cyc(4);
            chk({4'h0, gate}, ovr(lvl));
            src_pulse();
            chk({3'h0, SHUTDOWN_ACTIVE_O, gate}, {4'h0, WAVE_I ^ pol});
            rd(4'h3, q);
            chk(q, 8'h03);
            chk({7'h0, IRQ_O}, {7'h0, ien != 2'h0});
            wr(4'h4, 8'h03);
            cyc(2);
            chk({7'h0, IRQ_O}, 8'h00);
            rd(4'h4, q);
            chk(q, 8'h00);
            rd(4'hC, q);
            chk(q, 8'h00);
        end
        // unselected input ignored; generator off falls back to the override levels
        wr(4'h2, 8'h0E);
        rd(4'h2, q);
        chk(q, 8'h0E);
        SHUTDOWN_IN_I <= 4'h1;
        cyc(6);
        chk({3'h0, SHUTDOWN_ACTIVE_O, gate}, {4'h0, WAVE_I ^ pol});
        SHUTDOWN_IN_I <= 4'h0;
        wr(4'h1, {pol, 4'h0});
        cyc(3);
        chk({3'h0, SHUTDOWN_ACTIVE_O, gate}, ovr(lvl));
        // reset in mid-run: back to the shutdown state with levels cleared
        RESETN_I <= 1'b0;
        cyc(2);
        RESETN_I <= 1'b1;
        cyc(3);
        chk({3'h0, SHUTDOWN_ACTIVE_O, gate}, 8'h10);
        rd(4'h0, q);
        chk(q, 8'h80);
        summarize();
    end
endmodule
bind waveform_shutdown_restart waveform_shutdown_restart_asserts #(.NSRC(NSRC)) u_chk (.CLK_I(CLK_I),
    .RESETN_I(RESETN_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
    .WAVE_I(WAVE_I), .SRC_EDGE_I(SRC_EDGE_I), .SHUTDOWN_IN_I(SHUTDOWN_IN_I), .PIN_O(PIN_O),
    .SHUTDOWN_ACTIVE_O(SHUTDOWN_ACTIVE_O), .IRQ_O(IRQ_O));
`default_nettype wire

// ===== dv/waveform_shutdown_restart_asserts.sv
// port-level assertions of the shutdown and restart block
`timescale 1ns/1ps
`default_nettype none
`include "shutdown_map.vh"
module waveform_shutdown_restart_asserts #(
    parameter NSRC = 4
) (
    input wire logic                 CLK_I,
    input wire logic                 RESETN_I,
    input wire logic [`ADDR_W-1:0]   ADDR_I,
    input wire logic [`DATA_W-1:0]   WDATA_I,
    input wire logic                 WR_I,
    input wire logic                 RD_I,
    input wire logic [`DATA_W-1:0]   RDATA_O,
    input wire logic [3:0]           WAVE_I,
    input wire logic                 SRC_EDGE_I,
    input wire logic [NSRC-1:0]      SHUTDOWN_IN_I,
    input wire logic [3:0]           PIN_O,
    input wire logic                 SHUTDOWN_ACTIVE_O,
    input wire logic                 IRQ_O
);
    // ==========================================================
    // shadow copies of the writable fields except the flag and restart bits, plus a history of SRC_EDGE_I
    logic [3:0]      lvl;
    logic [3:0]      pol;
    logic [1:0]      ien;
    logic [NSRC-1:0] sel;
    logic            gen;
    logic [5:0]      src_h;
    wire logic       sd_any = |(SHUTDOWN_IN_I & sel);
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            lvl   <= 4'h0;
            pol   <= 4'h0;
            ien   <= 2'h0;
            sel   <= '0;
            gen   <= 1'b0;
            src_h <= 6'h00;
        end else begin
            src_h <= {src_h[4:0], SRC_EDGE_I};
            if (WR_I && ADDR_I == `REG_SHUTDOWN_CTL) lvl <= WDATA_I[3:0];
            if (WR_I && ADDR_I == `REG_GEN_CTL2) pol <= WDATA_I[7:4];
            if (WR_I && ADDR_I == `REG_GEN_CTL2) gen <= WDATA_I[1];
            if (WR_I && ADDR_I == `REG_IRQ_ENABLE) ien <= WDATA_I[1:0];
            if (WR_I && ADDR_I == `REG_SRC_SEL) sel <= WDATA_I[NSRC-1:0];
        end
    end
    // ==========================================================
    // properties
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RESETN_I);
    property p_ovr; SHUTDOWN_ACTIVE_O && !$past(WR_I) |-> PIN_O == {lvl[3], lvl[1], lvl[2], lvl[0]}; endproperty
    a_ovr: assert property (p_ovr) else $error("override levels wrong");
    property p_norm; gen && !SHUTDOWN_ACTIVE_O && !$past(WR_I) |-> PIN_O == ($past(WAVE_I) ^ pol); endproperty
    a_norm: assert property (p_norm) else $error("normal waveform wrong");
    property p_off; !gen && !$past(WR_I) |-> PIN_O == {lvl[3], lvl[1], lvl[2], lvl[0]}; endproperty
    a_off: assert property (p_off) else $error("generator off without override levels");
    property p_enter; sd_any [*3] |=> SHUTDOWN_ACTIVE_O; endproperty
    a_enter: assert property (p_enter) else $error("shutdown not entered");
    property p_hold; $fell(SHUTDOWN_ACTIVE_O) |-> |(src_h[4:0] & ~src_h[5:1]); endproperty
    a_hold: assert property (p_hold) else $error("resumed without source edge");
    property p_clr; $fell(SHUTDOWN_ACTIVE_O) |-> !$past(sd_any, 4); endproperty
    a_clr: assert property (p_clr) else $error("resumed while input high");
    property p_rdq; !$past(RD_I) |-> RDATA_O == 8'h00; endproperty
    a_rdq: assert property (p_rdq) else $error("read data outside read cycle");
    property p_unm; RD_I && ADDR_I >= 4'h4 && ADDR_I != 4'h5 |=> RDATA_O == 8'h00; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read not zero");
    property p_rd0; RD_I && ADDR_I == `REG_SHUTDOWN_CTL |=> RDATA_O[3:0] == lvl; endproperty
    a_rd0: assert property (p_rd0) else $error("override field readback wrong");
    property p_irqm; (ien == 2'h0) [*2] |-> !IRQ_O; endproperty
    a_irqm: assert property (p_irqm) else $error("masked interrupt raised");
endmodule
`default_nettype wire

// ===== inc/shutdown_map.vh
// register offsets, field positions and reset values of the shutdown and restart block
`ifndef SHUTDOWN_MAP_VH
`define SHUTDOWN_MAP_VH

`define ADDR_W           4
`define DATA_W           8
// ==========================================================
// register offsets
`define REG_SHUTDOWN_CTL 4'h0
`define REG_GEN_CTL2     4'h1
`define REG_SRC_SEL      4'h2
`define REG_IRQ_STATUS   4'h3
`define REG_IRQ_CLEAR    4'h4
`define REG_IRQ_ENABLE   4'h5
// ==========================================================
// shutdown control register fields
`define SD_FLAG_BIT      7
`define SD_LVL_BD_HI     3
`define SD_LVL_BD_LO     2
`define SD_LVL_AC_HI     1
`define SD_LVL_AC_LO     0
// generator control register two fields
`define GC_RESTART_BIT   0
`define GC_ENABLE_BIT    1
`define GC_POL_HI        7
`define GC_POL_LO        4
// interrupt status fields
`define IRQ_SHUTDOWN_BIT 0
`define IRQ_RESUME_BIT   1
`define IRQ_W            2
// ==========================================================
// reset values
`define RST_LEVELS       2'h0
`define RST_SRC_SEL      4'h0
`define RST_POL          4'h0
`define RST_IRQ          2'h0
`define RST_FLAG         1'h1
`define RST_BIT          1'h0
`define RST_PINS         4'h0
`define ZERO_BYTE        8'h00

`endif

// ===== src/rise_detect.v
// rising edge detector on an already synchronised level
`timescale 1ns/1ps
`default_nettype none
module rise_detect (
    input  wire clk_i,
    input  wire resetn_i,
    input  wire level_i,
    output wire rise_o
);
    reg prev;

    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            prev <= 1'b0;
        end else begin
            prev <= level_i;
        end
    end

    assign rise_o = level_i & ~prev;
endmodule
`default_nettype wire

// ===== src/sync2.v
// two flip-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
    parameter W = 1
) (
    input  wire         clk_i,
    input  wire         resetn_i,
    input  wire [W-1:0] d_i,
    output reg  [W-1:0] q_o
);
    reg [W-1:0] stage;

    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            stage <= {W{1'b0}};
            q_o   <= {W{1'b0}};
        end else begin
            stage <= d_i;
            q_o   <= stage;
        end
    end
endmodule
`default_nettype wire

// ===== src/waveform_shutdown_restart.v
// auto-shutdown override and restart logic of the complementary waveform generator
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "shutdown_map.vh"
module waveform_shutdown_restart #(
    parameter NSRC = 4
) (
    input  wire                 CLK_I,
    input  wire                 RESETN_I,
    // register port
    input  wire [`ADDR_W-1:0]   ADDR_I,
    input  wire [`DATA_W-1:0]   WDATA_I,
    input  wire                 WR_I,
    input  wire                 RD_I,
    output reg  [`DATA_W-1:0]   RDATA_O,
    // waveform core side, same clock
    input  wire [3:0]           WAVE_I,
    // input source of the generator and shutdown sources, from pins
    input  wire                 SRC_EDGE_I,
    input  wire [NSRC-1:0]      SHUTDOWN_IN_I,
    // pins a, b, c, d in bits 0..3
    output reg  [3:0]           PIN_O,
    output reg                  SHUTDOWN_ACTIVE_O,
    output reg                  IRQ_O
);
    // ==========================================================
    // input synchronisation
    wire [NSRC-1:0] sd_sync;
    wire            src_sync;
    wire            src_rise;

    sync2 #(.W(NSRC)) u_sd_sync (
        .clk_i    (CLK_I),
        .resetn_i (RESETN_I),
        .d_i      (SHUTDOWN_IN_I),
        .q_o      (sd_sync)
    );

    sync2 #(.W(1)) u_src_sync (
        .clk_i    (CLK_I),
        .resetn_i (RESETN_I),
        .d_i      (SRC_EDGE_I),
        .q_o      (src_sync)
    );

    rise_detect u_src_rise (
        .clk_i    (CLK_I),
        .resetn_i (RESETN_I),
        .level_i  (src_sync),
        .rise_o   (src_rise)
    );

    // ==========================================================
    // registers
    reg [1:0]        override_level_bd;
    reg [1:0]        override_level_ac;
    reg              shutdown_flag;
    reg              restart_en;
    reg              gen_en;
    reg [3:0]        polarity;
    reg [NSRC-1:0]   src_sel;
    reg [`IRQ_W-1:0] irq_status;
    reg [`IRQ_W-1:0] irq_enable;
    reg              override_hold;

    wire wr_sd   = WR_I && (ADDR_I == `REG_SHUTDOWN_CTL);
    wire wr_gc   = WR_I && (ADDR_I == `REG_GEN_CTL2);
    wire wr_src  = WR_I && (ADDR_I == `REG_SRC_SEL);
    wire wr_iclr = WR_I && (ADDR_I == `REG_IRQ_CLEAR);
    wire wr_ien  = WR_I && (ADDR_I == `REG_IRQ_ENABLE);

    wire sd_any  = |(sd_sync & src_sel);

    // ==========================================================
    // shutdown flag
    reg next_shutdown_flag;

    always @* begin
        next_shutdown_flag = shutdown_flag;
        if (sd_any) begin
            next_shutdown_flag = 1'b1;
        end else if (restart_en) begin
            next_shutdown_flag = 1'b0;
        end else if (wr_sd) begin
            // a clear only lands while no selected input is high
            next_shutdown_flag = WDATA_I[`SD_FLAG_BIT];
        end
    end

    // override stays until a source rising edge after the flag clears
    reg next_override_hold;

    // an edge in the very cycle the flag clears does not count
    wire resume_edge = src_rise & ~shutdown_flag;

    always @* begin
        next_override_hold = override_hold;
        if (next_shutdown_flag) begin
            next_override_hold = 1'b1;
        end else if (resume_edge) begin
            next_override_hold = 1'b0;
        end
    end

    // ==========================================================
    // shutdown state; start-up is from the shutdown state
    always @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            shutdown_flag <= `RST_FLAG;
            override_hold <= `RST_FLAG;
        end else begin
            shutdown_flag <= next_shutdown_flag;
            override_hold <= next_override_hold;
        end
    end

    // ==========================================================
    // override level fields
    always @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            override_level_bd <= `RST_LEVELS;
            override_level_ac <= `RST_LEVELS;
        end else begin
            if (wr_sd) begin
                override_level_bd <= WDATA_I[`SD_LVL_BD_HI:`SD_LVL_BD_LO];
                override_level_ac <= WDATA_I[`SD_LVL_AC_HI:`SD_LVL_AC_LO];
            end
        end
    end

    // ==========================================================
    // generator control register two
    // polarity is taken at once; a change shows on the next pin update
    always @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            restart_en <= `RST_BIT;
            gen_en     <= `RST_BIT;
            polarity   <= `RST_POL;
        end else begin
            if (wr_gc) begin
                restart_en <= WDATA_I[`GC_RESTART_BIT];
                gen_en     <= WDATA_I[`GC_ENABLE_BIT];
                polarity   <= WDATA_I[`GC_POL_HI:`GC_POL_LO];
            end
        end
    end

    // ==========================================================
    // shutdown source select
    // an unselected input is ignored entirely, even while it is high
    always @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            src_sel <= {NSRC{1'b0}};
        end else begin
            if (wr_src) begin
                src_sel <= WDATA_I[NSRC-1:0];
            end
        end
    end

    // ==========================================================
    // interrupts: set wins over clear
    wire [`IRQ_W-1:0] irq_set;
    wire [`IRQ_W-1:0] irq_clr;
    reg  [`IRQ_W-1:0] next_irq_status;

    assign irq_set[`IRQ_SHUTDOWN_BIT] = next_shutdown_flag & ~shutdown_flag;
    assign irq_set[`IRQ_RESUME_BIT]   = override_hold & ~next_override_hold;
    assign irq_clr                    = wr_iclr ? WDATA_I[`IRQ_W-1:0] : `RST_IRQ;

    // an event in the cycle of a clear must not be lost
    always @* begin
        next_irq_status = (irq_status & ~irq_clr) | irq_set;
    end

    always @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            irq_status <= `RST_IRQ;
            IRQ_O      <= `RST_BIT;
        end else begin
            irq_status <= next_irq_status;
            // one cycle behind the status bits, so the output stays a plain flop
            IRQ_O      <= |(irq_status & irq_enable);
        end
    end

    always @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            irq_enable <= `RST_IRQ;
        end else begin
            if (wr_ien) begin
                irq_enable <= WDATA_I[`IRQ_W-1:0];
            end
        end
    end

    // ==========================================================
    // read port, data one cycle after the strobe
    reg [`DATA_W-1:0] rd_mux;

    always @* begin
        rd_mux = `ZERO_BYTE;
        case (ADDR_I)
            `REG_SHUTDOWN_CTL: begin
                rd_mux[`SD_FLAG_BIT]                 = shutdown_flag;
                rd_mux[`SD_LVL_BD_HI:`SD_LVL_BD_LO] = override_level_bd;
                rd_mux[`SD_LVL_AC_HI:`SD_LVL_AC_LO] = override_level_ac;
            end
            `REG_GEN_CTL2: begin
                rd_mux[`GC_RESTART_BIT]        = restart_en;
                rd_mux[`GC_ENABLE_BIT]         = gen_en;
                rd_mux[`GC_POL_HI:`GC_POL_LO]  = polarity;
            end
            `REG_SRC_SEL: begin
                rd_mux[NSRC-1:0] = src_sel;
            end
            `REG_IRQ_STATUS: begin
                rd_mux[`IRQ_W-1:0] = irq_status;
            end
            `REG_IRQ_ENABLE: begin
                rd_mux[`IRQ_W-1:0] = irq_enable;
            end
            default: begin
                rd_mux = `ZERO_BYTE;
            end
        endcase
    end

    // the bus sits at zero outside the read cycle, so no hold is needed
    reg [`DATA_W-1:0] next_rdata;

    always @* begin
        next_rdata = `ZERO_BYTE;
        if (RD_I) begin
            next_rdata = rd_mux;
        end
    end

    always @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            RDATA_O <= `ZERO_BYTE;
        end else begin
            RDATA_O <= next_rdata;
        end
    end

    // ==========================================================
    // pin drive
    wire [3:0] override_pins;
    // bit order a, b, c, d
    assign override_pins = {override_level_bd[1], override_level_ac[1],
                            override_level_bd[0], override_level_ac[0]};

    reg [3:0] next_pin;

    always @* begin
        if (next_override_hold || !gen_en) begin
            // no polarity here on purpose
            next_pin = override_pins;
        end else begin
            next_pin = WAVE_I ^ polarity;
        end
    end

    always @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            PIN_O             <= `RST_PINS;
            SHUTDOWN_ACTIVE_O <= `RST_FLAG;
        end else begin
            SHUTDOWN_ACTIVE_O <= next_override_hold;
            PIN_O             <= next_pin;
        end
    end
endmodule
`default_nettype wire
